// file: core/emd_decoder.sv
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module emd_decoder
   import emd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // three request ports, one per source
   input  wire emd_pkg::emd_req_t   cpu_req,
   input  wire emd_pkg::emd_req_t   hub_req,
   input  wire emd_pkg::emd_req_t   gfx_req,
   output emd_pkg::emd_route_t      cpu_route,
   output emd_pkg::emd_route_t      hub_route,
   output emd_pkg::emd_route_t      gfx_route
);
   import emd_pkg::*;

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   logic [31:0] control_a_reg;          // segment and graphics memory control
   logic [31:0] fixed_hole_control_reg; // isa hole enable
   logic [31:0] top_of_main_memory_reg; // byte address of top of dram
   logic [31:0] register_window_base_reg;
   logic [31:0] aperture_base_reg;
   logic [31:0] misc_control_reg;
   logic [31:0] probe_addr_reg;         // software probe of the decoder
   logic [31:0] probe_result_reg;       // registered decode of the probe

   // ------------------------------------------------------------------
   // bus handshake state
   // ------------------------------------------------------------------
   logic        aw_held_reg;   // write address captured
   logic        w_held_reg;    // write data captured
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;       // both halves present, response free
   logic        wr_hit;        // write address maps to a writable register

   // ------------------------------------------------------------------
   // decode function, shared by all three sources and the probe
   // ------------------------------------------------------------------
   function automatic emd_route_t decode(input emd_req_t r);
      logic [35:0] a;
      logic [35:0] mtop;
      logic [35:0] seg_sz;
      logic [35:0] seg_base;
      logic [35:0] gbuf_sz;
      logic [35:0] gbuf_top;
      logic [35:0] gbuf_base;
      logic [35:0] win_base;
      logic [35:0] ap_base;
      logic [35:0] ap_sz;
      logic        seg_en;
      logic        gbuf_en;
      logic [1:0]  gsel;
      logic [9:0]  io_lo;
      emd_route_t  o;
      a         = r.addr;
      mtop      = {4'h0, top_of_main_memory_reg};
      seg_en    = control_a_reg[CA_TOPSEG_BIT];
      seg_sz    = control_a_reg[CA_SEG_SIZE_BIT] ? SIZE_1M : SIZE_512K;
      seg_base  = mtop - seg_sz;
      gsel      = control_a_reg[CA_GBUF_LSB +: 2];
      gbuf_en   = (gsel != 2'h0);
      gbuf_sz   = (gsel == 2'h2) ? SIZE_1M : SIZE_512K;
      gbuf_top  = seg_en ? seg_base : mtop;
      gbuf_base = gbuf_top - gbuf_sz;
      win_base  = {4'h0, register_window_base_reg[31:19], 19'h0};
      ap_sz     = misc_control_reg[MC_APER_64_BIT] ? SIZE_64M : SIZE_32M;
      ap_base   = misc_control_reg[MC_APER_64_BIT] ?
                  {4'h0, aperture_base_reg[31:26], 26'h0} :
                  {4'h0, aperture_base_reg[31:25], 25'h0};
      io_lo     = a[9:0];
      o.dest      = DST_HUB;
      o.fwd_addr  = a;
      o.drop      = 1'b0;
      o.claim_gfx = 1'b0;
      if (r.is_io) begin
         if ((io_lo >= VGA_IO_LO1 && io_lo <= VGA_IO_HI1) ||
             (io_lo >= VGA_IO_LO2 && io_lo <= VGA_IO_HI2)) begin
            o.dest      = DST_GFX;
            o.claim_gfx = 1'b1;
         end
      end else if (a >= FOUR_GB) begin
         o.dest = DST_HUB;
         o.drop = (r.src == SRC_CPU);
      end else if (a < EXT_BASE) begin
         // compatibility area is outside this block, passed to hub
         o.dest = DST_HUB;
      end else if (a < mtop) begin
         o.dest = DST_DRAM;
         if (fixed_hole_control_reg[FH_HOLE_EN_BIT] &&
             a >= HOLE_BASE && a < HOLE_END) begin
            o.dest = DST_HUB;
         end else if (seg_en && a >= seg_base) begin
            o.dest = (r.src == SRC_CPU && r.smm) ? DST_DRAM : DST_HUB;
         end else if (gbuf_en && a >= gbuf_base && a < gbuf_top) begin
            o.dest      = (r.src == SRC_GFX) ? DST_DRAM : DST_HUB;
            o.claim_gfx = (r.src == SRC_GFX);
         end
      end else if (a >= BIOS_BASE) begin
         o.dest = DST_HUB;
      end else if (a >= IOAPIC_END && a < GAP_END) begin
         o.dest = DST_HUB;
      end else if (a >= IOAPIC_BASE && a < IOAPIC_END) begin
         o.dest = DST_HUB;
      end else if (control_a_reg[CA_HISEG_BIT] &&
                   a >= HISEG_BASE && a < HISEG_END) begin
         o.dest     = DST_DRAM;
         o.fwd_addr = VGA_WIN_BASE | (a & HISEG_MASK);
      end else if (a >= win_base && a < win_base + SIZE_512K) begin
         o.dest      = DST_GFX;
         o.claim_gfx = 1'b1;
      end else if (a >= ap_base && a < ap_base + ap_sz) begin
         o.dest      = DST_GFX;
         o.claim_gfx = 1'b1;
      end else begin
         o.dest = DST_HUB;
      end
      return o;
   endfunction

   // ------------------------------------------------------------------
   // steering outputs
   // ------------------------------------------------------------------
   // combinational steering
   // combinational on purpose: the decode sits in the address path
   always_comb begin
      cpu_route = decode(cpu_req);
      hub_route = decode(hub_req);
      gfx_route = decode(gfx_req);
   end

   // ------------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------------
   // address and data may arrive in either order; each is held once taken
   assign s_axi_awready = ~aw_held_reg;
   assign s_axi_wready  = ~w_held_reg;
   assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;

   // write address hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   // write data hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   // writable offsets; the probe result is read only
   always_comb begin
      case (aw_addr_reg)
         OFS_CONTROL_A, OFS_FIXED_HOLE, OFS_TOP_OF_MAIN, OFS_REG_WIN_BASE,
         OFS_APERTURE_BASE, OFS_MISC_CONTROL, OFS_PROBE_ADDR: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // byte-lane merge of one register
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  stb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            m[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // ------------------------------------------------------------------
   // register updates
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_a_reg            <= RST_CONTROL_A;
         fixed_hole_control_reg   <= RST_FIXED_HOLE;
         top_of_main_memory_reg   <= RST_TOP_MAIN;
         register_window_base_reg <= RST_WIN_BASE;
         aperture_base_reg        <= RST_APER_BASE;
         misc_control_reg         <= RST_MISC;
         probe_addr_reg           <= 32'h0000_0000;
      end else if (wr_fire) begin
         case (aw_addr_reg)
            OFS_CONTROL_A:     control_a_reg <= merge(control_a_reg, w_data_reg,
                                                      w_strb_reg);
            OFS_FIXED_HOLE:    fixed_hole_control_reg <=
                                  merge(fixed_hole_control_reg, w_data_reg, w_strb_reg);
            OFS_TOP_OF_MAIN:   top_of_main_memory_reg <=
                                  merge(top_of_main_memory_reg, w_data_reg, w_strb_reg);
            OFS_REG_WIN_BASE:  register_window_base_reg <=
                                  merge(register_window_base_reg, w_data_reg, w_strb_reg);
            OFS_APERTURE_BASE: aperture_base_reg <=
                                  merge(aperture_base_reg, w_data_reg, w_strb_reg);
            OFS_MISC_CONTROL:  misc_control_reg <= merge(misc_control_reg, w_data_reg,
                                                         w_strb_reg);
            OFS_PROBE_ADDR:    probe_addr_reg <= merge(probe_addr_reg, w_data_reg,
                                                       w_strb_reg);
            default: begin
               // unmapped: nothing stored, slverr returned
            end
         endcase
      end
   end

   // probe result: destination one-hot in [2:0], drop [3], claim [4]
   // registered so software sees the live map for a cpu non-smm access
   always_ff @(posedge aclk) begin
      emd_route_t pr;
      pr = decode('{addr: {4'h0, probe_addr_reg}, src: SRC_CPU,
                    smm: 1'b0, is_io: 1'b0});
      if (!aresetn) begin
         probe_result_reg <= 32'h0000_0000;
      end else begin
         probe_result_reg <= {27'h0, pr.claim_gfx, pr.drop, pr.dest};
      end
   end

   // ------------------------------------------------------------------
   // write response
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------------
   // one read at a time: address refused while a read answer is pending
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         case (s_axi_araddr)
            OFS_CONTROL_A:     s_axi_rdata <= control_a_reg;
            OFS_FIXED_HOLE:    s_axi_rdata <= fixed_hole_control_reg;
            OFS_TOP_OF_MAIN:   s_axi_rdata <= top_of_main_memory_reg;
            OFS_REG_WIN_BASE:  s_axi_rdata <= register_window_base_reg;
            OFS_APERTURE_BASE: s_axi_rdata <= aperture_base_reg;
            OFS_MISC_CONTROL:  s_axi_rdata <= misc_control_reg;
            OFS_PROBE_ADDR:    s_axi_rdata <= probe_addr_reg;
            OFS_PROBE_RESULT:  s_axi_rdata <= probe_result_reg;
            default: begin
               // unmapped reads zero with slverr
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: dv/emd_decoder_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// fixed-range steering and bus holding checks
// ---------------------------------------------------------------
module emd_decoder_checker
   import emd_pkg::*;
(
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire emd_pkg::emd_req_t   cpu_req,
   input wire emd_pkg::emd_req_t   hub_req,
   input wire emd_pkg::emd_req_t   gfx_req,
   input wire emd_pkg::emd_route_t cpu_route,
   input wire emd_pkg::emd_route_t hub_route,
   input wire emd_pkg::emd_route_t gfx_route
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic [35:0] ca = cpu_req.addr; // processor address
   wire logic [35:0] ha = hub_req.addr; // hub link address
   wire logic [35:0] ga = gfx_req.addr; // graphics engine address
   a_bios_hub: assert property (ca >= BIOS_BASE && ca < FOUR_GB
      |-> cpu_route.dest == DST_HUB) else $error("bios access not on hub");
   a_gap_hub: assert property (ca >= IOAPIC_END && ca < GAP_END
      |-> cpu_route.dest == DST_HUB) else $error("gap access not on hub");
   a_same_steer: assert property ((ha >= IOAPIC_END && ha < GAP_END
      |-> hub_route.dest == DST_HUB) and (ga >= IOAPIC_END && ga < GAP_END
      |-> gfx_route.dest == DST_HUB)) else $error("gap steering differs by source");
   a_apic_hub: assert property (ca >= IOAPIC_BASE && ca < IOAPIC_END
      |-> cpu_route.dest == DST_HUB) else $error("apic access not on hub");
   a_high_drop: assert property (ca >= FOUR_GB |-> cpu_route.drop)
      else $error("access above 4 GB not dropped");
   a_drop_cpu: assert property (!hub_route.drop && !gfx_route.drop)
      else $error("drop raised for a non processor source");
   a_hiseg_remap: assert property (cpu_route.dest == DST_DRAM && ca >= HISEG_BASE
      && ca < HISEG_END |-> cpu_route.fwd_addr == (VGA_WIN_BASE | (ca & HISEG_MASK)))
      else $error("high segment address not remapped");
   a_dram_fwd: assert property (cpu_route.dest == DST_DRAM && ca < HISEG_BASE
      |-> cpu_route.fwd_addr == ca) else $error("dram address altered");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
endmodule
bind emd_decoder emd_decoder_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .cpu_req(cpu_req), .hub_req(hub_req), .gfx_req(gfx_req),
   .cpu_route(cpu_route), .hub_route(hub_route), .gfx_route(gfx_route));
`default_nettype wire

// file: dv/emd_req_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// requesters: processor bus, hub link, graphics engine
// ---------------------------------------------------------------
module emd_req_model
   import emd_pkg::*;
(
   input wire logic          aclk,
   output emd_pkg::emd_req_t cpu_req,
   output emd_pkg::emd_req_t hub_req,
   output emd_pkg::emd_req_t gfx_req,
   output logic              shown
);
   initial {cpu_req, hub_req, gfx_req, shown} = '0;
   // idle sources show the inverted address so a stale value never matches
   task automatic put(input emd_src_t s, input logic m, input logic io, input logic [35:0] a);
      @(posedge aclk);
      cpu_req <= (s == SRC_CPU) ? emd_req_t'{a, s, m, io} : emd_req_t'{~a, SRC_CPU, 1'b0, 1'b0};
      hub_req <= (s == SRC_HUB) ? emd_req_t'{a, s, m, io} : emd_req_t'{~a, SRC_HUB, 1'b0, 1'b0};
      gfx_req <= (s == SRC_GFX) ? emd_req_t'{a, s, m, io} : emd_req_t'{~a, SRC_GFX, 1'b0, 1'b0};
      shown <= 1'b1;
      @(posedge aclk);
      shown <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import emd_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, shown;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;  // register offsets
   logic [31:0] wdata, rdata;    // bus data
   logic [3:0]  wstrb;           // byte lanes
   logic [1:0]  bresp, rresp;    // responses
   emd_req_t    cpu_req, hub_req, gfx_req;
   emd_route_t  cpu_route, hub_route, gfx_route;
   int          err_count, checked;
   emd_route_t  q_rt[$];         // expected routes
   emd_src_t    q_s[$];          // source of each expected route
   logic [33:0] q_rd[$];         // expected {rresp, rdata}
   logic [1:0]  q_wr[$];         // expected bresp
   logic [31:0] rst_v [6] = '{RST_CONTROL_A, RST_FIXED_HOLE, RST_TOP_MAIN,
                               RST_WIN_BASE, RST_APER_BASE, RST_MISC};
   emd_decoder u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cpu_req(cpu_req), .hub_req(hub_req), .gfx_req(gfx_req),
      .cpu_route(cpu_route), .hub_route(hub_route), .gfx_route(gfx_route));
   emd_req_model u_src (.aclk(aclk), .cpu_req(cpu_req), .hub_req(hub_req),
      .gfx_req(gfx_req), .shown(shown));
   always #25 aclk = ~aclk;
   task automatic judge(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // forwarded address only matters where dram is the target
   task automatic cmp_route(input emd_src_t s, input emd_route_t e);
      emd_route_t g;
      g = (s == SRC_CPU) ? cpu_route : (s == SRC_HUB) ? hub_route : gfx_route;
      if (e.dest != DST_DRAM) g.fwd_addr = e.fwd_addr;
      judge(64'(g), 64'(e));
   endtask
   task automatic cmp_rd(input logic [33:0] e); judge(64'({rresp, rdata}), 64'(e)); endtask
   task automatic cmp_wr(input logic [1:0] e); judge(64'(bresp), 64'(e)); endtask
   // results are compared as they appear on the ports
   always @(negedge aclk) begin
      if (shown) cmp_route(q_s.pop_front(), q_rt.pop_front());
      if (rvalid && rready) cmp_rd(q_rd.pop_front());
      if (bvalid && bready) cmp_wr(q_wr.pop_front());
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      q_wr.push_back(r);
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 2'b11, 1'($urandom % 2)};
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) bready <= !bready;
      end while (!(bvalid && bready));
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
      q_rd.push_back({r, d});
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 1'b1, 1'($urandom % 2)};
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) rready <= !rready;
      end while (!(rvalid && rready));
   endtask
   task automatic chk(input emd_src_t s, input logic [35:0] a, input emd_dest_t d,
                      input logic cl = 1'b0, m = 1'b0, io = 1'b0, dr = 1'b0);
      emd_route_t e;
      e.dest = d;
      e.drop = dr;
      e.claim_gfx = cl;
      e.fwd_addr = (a >= HISEG_BASE && a < HISEG_END) ? (VGA_WIN_BASE | (a & HISEG_MASK)) : a;
      q_s.push_back(s);
      q_rt.push_back(e);
      u_src.put(s, m, io, a);
   endtask
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(50 * 20000);
      err_count++;
      final_report();
   end
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      {awaddr, araddr, wdata, err_count, checked} = '0;
      wstrb = 4'hF;
      void'($urandom(78));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(i * 4), 2'b00, rst_v[i]);
      rd(8'h20, 2'b10, 32'h0000_0000);
      wr(8'h20, 32'hFFFF_FFFF, 2'b10);
      wr(OFS_PROBE_RESULT, 32'h0000_0001, 2'b10);
      // ranges kept apart and off the apic and bios areas
      wr(OFS_TOP_OF_MAIN, 32'h0200_0000, 2'b00);
      wr(OFS_FIXED_HOLE, 32'h0000_0080, 2'b00);
      wr(OFS_CONTROL_A, 32'h0000_0013, 2'b00);
      wr(OFS_REG_WIN_BASE, 32'hD000_0000, 2'b00);
      wr(OFS_APERTURE_BASE, 32'hE000_0000, 2'b00);
      rd(OFS_CONTROL_A, 2'b00, 32'h0000_0013);
      chk(SRC_CPU, 36'h0_0010_0000, DST_DRAM);
      chk(SRC_CPU, 36'h0_00F0_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_00FF_FFFF, DST_HUB);
      chk(SRC_CPU, 36'h0_0100_0000, DST_DRAM);
      chk(SRC_CPU, 36'h0_01F0_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_01FF_FFFF, DST_DRAM, 1'b0, 1'b1);
      chk(SRC_HUB, 36'h0_01F0_0000, DST_HUB, 1'b0, 1'b1);
      chk(SRC_GFX, 36'h0_01E8_0000, DST_DRAM, 1'b1);
      chk(SRC_CPU, 36'h0_01EF_FFFF, DST_HUB, 1'b0, 1'b1);
      chk(SRC_CPU, 36'h0_01E7_FFFF, DST_DRAM);
      chk(SRC_CPU, 36'h0_0200_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_D000_0000, DST_GFX, 1'b1);
      chk(SRC_CPU, 36'h0_D007_FFFF, DST_GFX, 1'b1);
      chk(SRC_CPU, 36'h0_D008_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_E1FF_FFFF, DST_GFX, 1'b1);
      chk(SRC_CPU, 36'h0_E200_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_0000_03C0, DST_GFX, 1'b1, 1'b0, 1'b1);
      chk(SRC_CPU, 36'h0_FECF_F000, DST_HUB);
      chk(SRC_CPU, 36'h0_FEDF_FFFF, DST_HUB);
      chk(SRC_GFX, 36'h0_FFE0_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_FEEA_0000, DST_HUB);
      chk(SRC_CPU, 36'h1_0000_0000, DST_HUB, 1'b0, 1'b0, 1'b0, 1'b1);
      chk(SRC_HUB, 36'h1_0000_0000, DST_HUB);
      wr(OFS_MISC_CONTROL, 32'h0000_0001, 2'b00);
      chk(SRC_CPU, 36'h0_E3FF_FFFF, DST_GFX, 1'b1);
      chk(SRC_CPU, 36'h0_E400_0000, DST_HUB);
      wr(OFS_CONTROL_A, 32'h0000_0015, 2'b00);
      chk(SRC_CPU, 36'h0_FEEB_FFFF, DST_DRAM);
      chk(SRC_GFX, 36'h0_01F0_0000, DST_DRAM, 1'b1);
      chk(SRC_CPU, 36'h0_01F8_0000, DST_HUB);
      chk(SRC_CPU, 36'h0_01EF_FFFF, DST_DRAM);
      wr(OFS_CONTROL_A, 32'h0000_0020, 2'b00);
      chk(SRC_GFX, 36'h0_01F0_0000, DST_DRAM, 1'b1);
      chk(SRC_CPU, 36'h0_01FF_FFFF, DST_HUB, 1'b0, 1'b1);
      chk(SRC_CPU, 36'h0_01EF_FFFF, DST_DRAM);
      repeat (8) begin
         chk(emd_src_t'($urandom % 3), 36'h0_FED0_0000 + 36'($urandom & 32'h000F_FFFF),
             DST_HUB);
      end
      wr(OFS_PROBE_ADDR, 32'hFFE0_0000, 2'b00);
      rd(OFS_PROBE_RESULT, 2'b00, 32'h0000_0002);
      repeat (3) @(posedge aclk);
      final_report();
   end
endmodule
`default_nettype wire

// file: inc/emd_pkg.sv
// ----------------------------------------------------------------------
// extended memory decoder package
// ----------------------------------------------------------------------
package emd_pkg;

   // ------------------------------------------------------------------
   // register byte offsets on the axi4-lite slave
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL_A      = 8'h00; // segment and graphics memory control
   localparam logic [7:0] OFS_FIXED_HOLE     = 8'h04; // fixed_hole_control
   localparam logic [7:0] OFS_TOP_OF_MAIN    = 8'h08; // top_of_main_memory
   localparam logic [7:0] OFS_REG_WIN_BASE   = 8'h0C; // register_window_base
   localparam logic [7:0] OFS_APERTURE_BASE  = 8'h10; // aperture_base
   localparam logic [7:0] OFS_MISC_CONTROL   = 8'h14; // misc_control
   localparam logic [7:0] OFS_PROBE_ADDR     = 8'h18; // decode probe address
   localparam logic [7:0] OFS_PROBE_RESULT   = 8'h1C; // decode probe result

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CA_TOPSEG_BIT    = 0;  // top_control_a_segment enable
   localparam int CA_SEG_SIZE_BIT  = 1;  // segment_size_select: 0=512 KB, 1=1 MB
   localparam int CA_HISEG_BIT     = 2;  // high_control_a_segment enable
   localparam int CA_GBUF_LSB      = 4;  // graphics_memory_select, 2 bits
   localparam int FH_HOLE_EN_BIT   = 7;  // isa hole enable
   localparam int MC_APER_64_BIT   = 0;  // aperture size: 0=32 MB, 1=64 MB

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] RST_CONTROL_A  = 32'h0000_0000;
   localparam logic [31:0] RST_FIXED_HOLE = 32'h0000_0000;
   localparam logic [31:0] RST_TOP_MAIN   = 32'h0100_0000; // 16 MB
   localparam logic [31:0] RST_WIN_BASE   = 32'h0000_0000;
   localparam logic [31:0] RST_APER_BASE  = 32'h0000_0000;
   localparam logic [31:0] RST_MISC       = 32'h0000_0000;

   // ------------------------------------------------------------------
   // address map constants
   // ------------------------------------------------------------------
   localparam logic [35:0] EXT_BASE      = 36'h0_0010_0000; // 1 MB
   localparam logic [35:0] FOUR_GB       = 36'h1_0000_0000;
   localparam logic [35:0] HOLE_BASE     = 36'h0_00F0_0000; // 15 MB
   localparam logic [35:0] HOLE_END      = 36'h0_0100_0000; // 16 MB
   localparam logic [35:0] SIZE_512K     = 36'h0_0008_0000;
   localparam logic [35:0] SIZE_1M       = 36'h0_0010_0000;
   localparam logic [35:0] SIZE_32M      = 36'h0_0200_0000;
   localparam logic [35:0] SIZE_64M      = 36'h0_0400_0000;
   localparam logic [35:0] IOAPIC_BASE   = 36'h0_FEC0_0000;
   localparam logic [35:0] IOAPIC_END    = 36'h0_FED0_0000;
   localparam logic [35:0] GAP_END       = 36'h0_FEE0_0000; // gap ends at FEDF_FFFF
   localparam logic [35:0] BIOS_BASE     = 36'h0_FFE0_0000; // top 2 MB
   localparam logic [35:0] HISEG_BASE    = 36'h0_FEEA_0000;
   localparam logic [35:0] HISEG_END     = 36'h0_FEEC_0000;
   localparam logic [35:0] VGA_WIN_BASE  = 36'h0_000A_0000;
   localparam logic [35:0] HISEG_MASK    = 36'h0_0001_FFFF; // 128 KB offset

   // legacy display i/o ranges on a[9:0]
   localparam logic [9:0] VGA_IO_LO1 = 10'h3B0;
   localparam logic [9:0] VGA_IO_HI1 = 10'h3BB;
   localparam logic [9:0] VGA_IO_LO2 = 10'h3C0;
   localparam logic [9:0] VGA_IO_HI2 = 10'h3DF;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      DST_DRAM = 3'h1,   // main dram
      DST_HUB  = 3'h2,   // hub link toward pci
      DST_GFX  = 3'h4    // internal graphics resources
   } emd_dest_t;

   typedef enum logic [1:0] {
      SRC_CPU = 2'h0,
      SRC_HUB = 2'h1,
      SRC_GFX = 2'h2
   } emd_src_t;

   // one access to be steered
   typedef struct packed {
      logic [35:0] addr;   // physical address, 36-bit processor space
      emd_src_t    src;    // originating interface
      logic        smm;    // processor is in system management mode
      logic        is_io;  // i/o cycle rather than memory
   } emd_req_t;

   // steering answer
   typedef struct packed {
      emd_dest_t   dest;       // where the access goes
      logic [35:0] fwd_addr;   // address presented at the destination
      logic        drop;       // completed locally, writes dropped, reads zero
      logic        claim_gfx;  // claimed by graphics: display i/o, window, aperture, or graphics memory for the graphics engine
   } emd_route_t;

endpackage
